// ---- logic/lcd_host_params.svh ----
// Offsets, field positions, reset values and counts for the LCD host port.
// Contract
// - Bus-style strap high means enable strobe handshake
// - Parallel strap selects eight-bit bus or serial
// - Serial mode is write only, never drives
// - Serial mode floats and ignores data bits 0-5
// - Select line and direction choose data, status, command
// - Drive-power strap picks normal or high power
// - Divider strap picks internal or external resistors
// - Access only when both chip selects active
// - Write strobe rising edge captures bus data
// - Read/write level high reads, enable strobes high
// - Reset pin low returns settings to defaults
`ifndef LCD_HOST_PARAMS_SVH
`define LCD_HOST_PARAMS_SVH
`define REG_STRAPS      4'h0
`define REG_RX          4'h4
`define REG_RD_DATA     4'h8
`define REG_STATUS      4'hC
`define STRAP_STYLE_BIT 0
`define STRAP_PAR_BIT   1
`define STRAP_PWR_BIT   2
`define STRAP_DIV_BIT   3
`define STRAP_SEL_BIT   4
`define RX_DC_BIT       8
`define RX_VALID_BIT    9
`define RX_OVR_BIT      10
`define RD_DATA_RST     8'h00
// Idle pin levels: selects off, strobes high, init, power and divider straps high, parallel 8080 bus.
`define PIN_IDLE_RST    18'h003D9
`define STATUS_RST      8'h00
`define SER_LAST_BIT    3'h7
`endif

// ---- logic/lcd_host_pkg.sv ----
// Types shared by the LCD host port modules.
package lcd_host_pkg;
  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_e;
  typedef struct packed {
    logic [7:0] data;
    logic       init_n;
    logic       div_int;
    logic       pwr_n;
    logic       par;
    logic       style;
    logic       wr;
    logic       rd;
    logic       dc;
    logic       cs2;
    logic       cs1_n;
  } pin_sample_s;
endpackage

// ---- logic/pin_sync_if.sv ----
// Carrier for raw pin levels and their synchronised copies.
`timescale 1ns/1ns
interface pin_sync_if;
  import lcd_host_pkg::*;
  pin_sample_s raw;
  pin_sample_s synced;
  modport sync_side (input raw, output synced);
  modport user_side (output raw, input synced);
endinterface

// ---- logic/pin_sync.sv ----
// Two-stage synchroniser for every pin that enters from the host side.
`timescale 1ns/1ns
`include "lcd_host_params.svh"
module pin_sync
  import lcd_host_pkg::*;
(
  // Clock and reset
  input  wire logic   ref_clk,
  input  wire logic   nrst,
  // Pins
  pin_sync_if.sync_side pins
);
  pin_sample_s meta_reg;
  pin_sample_s meta_next;
  pin_sample_s sync_reg;
  pin_sample_s sync_next;

  always_comb begin
    meta_next = pins.raw;
    sync_next = meta_reg;
  end

  // The first stage is read only by the second stage.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      // Idle levels here keep a strobe edge or an init pulse from appearing after reset.
      meta_reg <= `PIN_IDLE_RST;
      sync_reg <= `PIN_IDLE_RST;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign pins.synced = sync_reg;
endmodule

// ---- logic/lcd_host_port.sv ----
// Host bus port of the LCD controller with an Avalon-MM register view.
//
// Chosen here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ns
`include "lcd_host_params.svh"
module lcd_host_port
  import lcd_host_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Host pins
  input  wire logic        chip_select_low_n,
  input  wire logic        chip_select_high,
  input  wire logic        data_command_select,
  input  wire logic        rd_strobe,
  input  wire logic        wr_strobe,
  input  wire logic        init_low_n,
  input  wire logic [7:0]  data_in,
  output logic      [7:0]  data_out,
  output logic      [7:0]  data_oe_n,
  // Straps
  input  wire logic        bus_style_select,
  input  wire logic        parallel_select,
  input  wire logic        supply_power_mode_n,
  input  wire logic        internal_divider_select,
  // Supply control
  output logic             supply_normal_mode,
  output logic             use_internal_divider,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);
  pin_sync_if  pins ();
  pin_sample_s s;

  assign pins.raw = '{data: data_in, init_n: init_low_n, div_int: internal_divider_select,
                      pwr_n: supply_power_mode_n, par: parallel_select,
                      style: bus_style_select, wr: wr_strobe, rd: rd_strobe,
                      dc: data_command_select, cs2: chip_select_high,
                      cs1_n: chip_select_low_n};
  assign s = pins.synced;

  pin_sync u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .pins    (pins)
  );

  bus_state_e  state_reg,   state_next;
  logic        prev_rd_reg, prev_rd_next;
  logic        prev_wr_reg, prev_wr_next;
  logic        prev_sck_reg, prev_sck_next;
  logic [6:0]  shift_reg,   shift_next;
  logic [2:0]  cnt_reg,     cnt_next;
  logic [7:0]  rx_byte_reg, rx_byte_next;
  logic        rx_dc_reg,   rx_dc_next;
  logic        rx_valid_reg, rx_valid_next;
  logic        rx_ovr_reg,  rx_ovr_next;
  logic [7:0]  rd_data_reg, rd_data_next;
  logic [7:0]  status_reg,  status_next;
  logic [7:0]  dout_reg,    dout_next;
  logic [7:0]  oe_n_reg,    oe_n_next;
  logic        pwr_reg,     pwr_next;
  logic        div_reg,     div_next;
  logic [31:0] rdata_reg,   rdata_next;
  logic        wait_reg,    wait_next;
  logic        sel;
  logic        cap;
  logic [7:0]  cap_byte;
  logic        cap_dc;
  logic        drive;
  logic        take;

  always_comb begin
    sel           = !s.cs1_n && s.cs2;
    cap           = 1'b0;
    cap_byte      = s.data;
    cap_dc        = s.dc;
    drive         = 1'b0;
    prev_rd_next  = s.rd;
    prev_wr_next  = s.wr;
    prev_sck_next = s.data[6];
    shift_next    = shift_reg;
    cnt_next      = cnt_reg;
    if (s.par) begin
      cnt_next = 3'h0;
      if (s.style) begin
        // Enable high strobes; level high reads, falling enable writes.
        drive = sel && s.rd && s.wr;
        cap   = sel && prev_rd_reg && !s.rd && !s.wr;
      end else begin
        drive = sel && !s.rd;
        cap   = sel && !prev_wr_reg && s.wr;
      end
    end else if (!sel) begin
      cnt_next = 3'h0;
    end else if (s.data[6] && !prev_sck_reg) begin
      // Bit 7 carries data, bit 6 the clock; bits 0-5 are not looked at.
      shift_next = {shift_reg[5:0], s.data[7]};
      cnt_next   = cnt_reg + 3'h1;
      if (cnt_reg == `SER_LAST_BIT) begin
        cap      = 1'b1;
        cap_byte = {shift_reg, s.data[7]};
        cnt_next = 3'h0;
      end
    end
    // Select high reads display data, low reads status.
    dout_next = s.dc ? rd_data_reg : status_reg;
    oe_n_next = drive ? 8'h00 : 8'hFF;
    pwr_next  = s.pwr_n;
    div_next  = s.div_int;
    rx_byte_next = cap ? cap_byte : rx_byte_reg;
    rx_dc_next   = cap ? cap_dc : rx_dc_reg;
    rx_ovr_next  = rx_ovr_reg || (cap && rx_valid_reg);
    rx_valid_next = rx_valid_reg;
    rd_data_next = rd_data_reg;
    status_next  = status_reg;
    state_next   = state_reg;
    wait_next    = wait_reg;
    rdata_next   = rdata_reg;
    take         = 1'b0;
    case (state_reg)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          state_next = BUS_ANSWER;
          wait_next  = 1'b0;
          rdata_next = 32'h0000_0000;
          case (avs_address)
            `REG_STRAPS: begin
              rdata_next[`STRAP_STYLE_BIT] = s.style;
              rdata_next[`STRAP_PAR_BIT]   = s.par;
              rdata_next[`STRAP_PWR_BIT]   = pwr_reg;
              rdata_next[`STRAP_DIV_BIT]   = div_reg;
              rdata_next[`STRAP_SEL_BIT]   = sel;
            end
            `REG_RX: begin
              // A byte caught at this edge goes into the answer, so the clear cannot lose it.
              rdata_next[7:0]           = rx_byte_next;
              rdata_next[`RX_DC_BIT]    = rx_dc_next;
              rdata_next[`RX_VALID_BIT] = rx_valid_reg || cap;
              rdata_next[`RX_OVR_BIT]   = rx_ovr_next;
            end
            `REG_RD_DATA: rdata_next[7:0] = rd_data_reg;
            `REG_STATUS:  rdata_next[7:0] = status_reg;
            default:      rdata_next = 32'h0000_0000;
          endcase
        end
      end
      BUS_ANSWER: begin
        state_next = BUS_IDLE;
        wait_next  = 1'b1;
        take       = 1'b1;
        if (avs_write && avs_byteenable[0]) begin
          if (avs_address == `REG_RD_DATA) rd_data_next = avs_writedata[7:0];
          if (avs_address == `REG_STATUS)  status_next  = avs_writedata[7:0];
        end
      end
      default: begin
        state_next = BUS_IDLE;
        wait_next  = 1'b1;
      end
    endcase
    // Reading the receive register clears its flags; a new byte still wins.
    if (take && avs_read && avs_address == `REG_RX) begin
      rx_valid_next = 1'b0;
      rx_ovr_next   = 1'b0;
    end
    if (cap) begin
      rx_valid_next = 1'b1;
      rx_ovr_next   = rx_ovr_next || rx_valid_reg;
    end
    if (!s.init_n) begin
      shift_next    = 7'h00;
      cnt_next      = 3'h0;
      rx_byte_next  = 8'h00;
      rx_dc_next    = 1'b0;
      rx_valid_next = 1'b0;
      rx_ovr_next   = 1'b0;
      rd_data_next  = `RD_DATA_RST;
      status_next   = `STATUS_RST;
      oe_n_next     = 8'hFF;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg    <= BUS_IDLE;
      prev_rd_reg  <= 1'b1;
      prev_wr_reg  <= 1'b1;
      prev_sck_reg <= 1'b0;
      shift_reg    <= 7'h00;
      cnt_reg      <= 3'h0;
      rx_byte_reg  <= 8'h00;
      rx_dc_reg    <= 1'b0;
      rx_valid_reg <= 1'b0;
      rx_ovr_reg   <= 1'b0;
      rd_data_reg  <= `RD_DATA_RST;
      status_reg   <= `STATUS_RST;
      dout_reg     <= 8'h00;
      oe_n_reg     <= 8'hFF;
      pwr_reg      <= 1'b1;
      div_reg      <= 1'b1;
      rdata_reg    <= 32'h0000_0000;
      wait_reg     <= 1'b1;
    end else begin
      state_reg    <= state_next;
      prev_rd_reg  <= prev_rd_next;
      prev_wr_reg  <= prev_wr_next;
      prev_sck_reg <= prev_sck_next;
      shift_reg    <= shift_next;
      cnt_reg      <= cnt_next;
      rx_byte_reg  <= rx_byte_next;
      rx_dc_reg    <= rx_dc_next;
      rx_valid_reg <= rx_valid_next;
      rx_ovr_reg   <= rx_ovr_next;
      rd_data_reg  <= rd_data_next;
      status_reg   <= status_next;
      dout_reg     <= dout_next;
      oe_n_reg     <= oe_n_next;
      pwr_reg      <= pwr_next;
      div_reg      <= div_next;
      rdata_reg    <= rdata_next;
      wait_reg     <= wait_next;
    end
  end

  assign data_out             = dout_reg;
  assign data_oe_n            = oe_n_reg;
  assign supply_normal_mode   = pwr_reg;
  assign use_internal_divider = div_reg;
  assign avs_readdata         = rdata_reg;
  assign avs_waitrequest      = wait_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  serial_no_drive_a: assert property (!s.par |=> data_oe_n == 8'hFF)
    else $error("data pins driven in serial mode");
  deselect_float_a: assert property (!sel |=> data_oe_n == 8'hFF)
    else $error("data pins driven while deselected");
  wr_edge_capture_a: assert property ((s.par && !s.style && sel && s.wr && !prev_wr_reg
      && s.init_n) |=> rx_valid_reg && rx_byte_reg == $past(s.data))
    else $error("write strobe rising edge did not capture the bus");
  enable_read_a: assert property ((s.par && s.style && sel && s.rd && s.wr && s.init_n)
      |=> data_oe_n == 8'h00)
    else $error("enable-style read did not drive the bus");
  rd_select_a: assert property ((s.par && !s.style && sel && !s.rd && s.init_n)
      |=> data_oe_n == 8'h00
      && data_out == ($past(s.dc) ? $past(rd_data_reg) : $past(status_reg)))
    else $error("read returned the wrong source");
  power_mode_a: assert property (##1 supply_normal_mode == $past(s.pwr_n))
    else $error("supply mode does not follow its strap");
  divider_mode_a: assert property (##1 use_internal_divider == $past(s.div_int))
    else $error("divider choice does not follow its strap");
  serial_byte_a: assert property ((!s.par && sel && s.data[6] && !prev_sck_reg
      && cnt_reg == `SER_LAST_BIT && s.init_n)
      |=> rx_valid_reg && rx_byte_reg == {$past(shift_reg), $past(s.data[7])}
      && rx_dc_reg == $past(s.dc))
    else $error("serial byte not assembled after eighth clock");
  init_defaults_a: assert property (!s.init_n |=> !rx_valid_reg && cnt_reg == 3'h0
      && status_reg == `STATUS_RST)
    else $error("init pin did not restore defaults");
  bus_answer_a: assert property ((state_reg == BUS_IDLE && (avs_read || avs_write))
      |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");

  cover_par_write_c:    cover property (s.par && !s.style && sel && s.wr && !prev_wr_reg);
  cover_enable_read_c:  cover property (s.par && s.style && sel && s.rd && s.wr);
  cover_serial_byte_c:  cover property (!s.par && sel && cnt_reg == `SER_LAST_BIT
                                        && s.data[6] && !prev_sck_reg);
  cover_overrun_c:      cover property (rx_ovr_reg);
endmodule

// ---- bench/host_model.sv ----
// Host processor model that drives the LCD port pins in all three bus styles.
`timescale 1ns/1ns
module host_model (
  // Clock
  input  wire logic       ref_clk,
  // Pins
  input  wire logic [7:0] bus,
  output logic            cs1_n,
  output logic            cs2,
  output logic            dc,
  output logic            rd,
  output logic            wr,
  output logic [7:0]      dq
);
  initial begin
    cs1_n = 1'b1;
    cs2 = 1'b0;
    dc = 1'b0;
    rd = 1'b1;
    wr = 1'b1;
    dq = 8'h00;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // Strobe phases of five and four cycles stay above the two the synchroniser needs.
  task automatic xfer(input logic s68, sel, w, d, input logic [7:0] b, output logic [7:0] q);
    cs1_n <= 1'b0;
    cs2 <= sel;
    dc <= d;
    if (w) dq <= b;
    if (s68) wr <= !w;
    if (s68) rd <= 1'b1;
    else if (w) wr <= 1'b0;
    else rd <= 1'b0;
    wt(5);
    q = bus;
    rd <= s68 ? 1'b0 : 1'b1;
    // The read/write level must outlast the falling enable that latches a write.
    if (!s68) wr <= 1'b1;
    wt(4);
    wr <= 1'b1;
    cs2 <= 1'b0;
    dq <= ~dq;
    wt(1);
  endtask
  // Strobes stay still here; the unused data bits change on every bit.
  task automatic ser(input logic d, input logic [7:0] b);
    cs1_n <= 1'b0;
    cs2 <= 1'b1;
    dc <= d;
    for (int i = 7; i >= 0; i--) begin
      dq <= {b[i], 1'b0, 6'(i * 9)};
      wt(4);
      dq[6] <= 1'b1;
      wt(4);
    end
    dq[6] <= 1'b0;
    wt(4);
    cs2 <= 1'b0;
    wt(1);
  endtask
  task automatic idle(input logic s68);
    rd <= !s68;
    wr <= 1'b1;
    wt(1);
  endtask
endmodule

// ---- bench/tb_lcd_host_port.sv ----
// Self-checking bench for the LCD host port.
`timescale 1ns/1ns
module tb_lcd_host_port;
  logic        ref_clk, nrst, init_low_n, style, par, pwr_n, div;
  logic        cs1_n, cs2, dc, rd, wr, smode, sdiv, drove;
  logic [7:0]  dq, data_in, data_out, data_oe_n, q;
  logic [3:0]  avs_address, avs_byteenable;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, r;
  int          num_errors, n_compared;
  assign data_in = (data_oe_n & dq) | (~data_oe_n & data_out);
  lcd_host_port lcd_host_port_inst (.ref_clk(ref_clk), .nrst(nrst),
    .chip_select_low_n(cs1_n), .chip_select_high(cs2), .data_command_select(dc),
    .rd_strobe(rd), .wr_strobe(wr), .init_low_n(init_low_n), .data_in(data_in),
    .data_out(data_out), .data_oe_n(data_oe_n), .bus_style_select(style),
    .parallel_select(par), .supply_power_mode_n(pwr_n), .internal_divider_select(div),
    .supply_normal_mode(smode), .use_internal_divider(sdiv), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  host_model host_model_inst (.ref_clk(ref_clk), .bus(data_in), .cs1_n(cs1_n), .cs2(cs2),
    .dc(dc), .rd(rd), .wr(wr), .dq(dq));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (data_oe_n !== 8'hFF) drove <= 1'b1;
  task automatic chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk(n, e, r);
  endtask
  task automatic t_reset;
    repeat (3) @(posedge ref_clk);
    chk("oe_n", 32'hFF, 32'(data_oe_n));
    chk("supply", 32'h3, {30'h0, smode, sdiv});
    chk("wait", 32'h1, 32'(avs_waitrequest));
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
  endtask
  task automatic t_regs;
    rchk("straps", 4'h0, 32'h0000000E);
    chk("supply", 32'h3, {30'h0, smode, sdiv});
    av(1'b1, 4'h2, 32'hFFFFFFFF);
    rchk("unmapped", 4'h2, 32'h0);
    av(1'b1, 4'h8, 32'hFFFFFFA5);
    av(1'b1, 4'hC, 32'h0000003C);
    rchk("rd_data", 4'h8, 32'hA5);
    avs_byteenable <= 4'hE;
    av(1'b1, 4'h8, 32'h0000_0011);
    avs_byteenable <= 4'h1;
    rchk("be ignored", 4'h8, 32'hA5);
  endtask
  task automatic t_8080;
    host_model_inst.xfer(1'b0, 1'b1, 1'b1, 1'b1, 8'h5A, q);
    rchk("rx data", 4'h4, 32'h35A);
    host_model_inst.xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'h81, q);
    rchk("rx cmd", 4'h4, 32'h281);
    host_model_inst.xfer(1'b0, 1'b1, 1'b0, 1'b1, 8'h00, q);
    chk("rd data", 32'hA5, 32'(q));
    host_model_inst.xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, q);
    chk("rd status", 32'h3C, 32'(q));
    drove = 1'b0;
    host_model_inst.xfer(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, q);
    chk("desel drive", 32'h0, 32'(drove));
    host_model_inst.xfer(1'b0, 1'b0, 1'b1, 1'b1, 8'h77, q);
    rchk("desel rx", 4'h4, 32'h81);
  endtask
  task automatic t_6800;
    @(posedge ref_clk);
    style <= 1'b1;
    host_model_inst.idle(1'b1);
    host_model_inst.wt(4);
    host_model_inst.xfer(1'b1, 1'b1, 1'b1, 1'b1, 8'h96, q);
    rchk("rx 6800", 4'h4, 32'h396);
    host_model_inst.xfer(1'b1, 1'b1, 1'b0, 1'b0, 8'h00, q);
    chk("rd 6800", 32'h3C, 32'(q));
  endtask
  task automatic t_serial;
    @(posedge ref_clk);
    style <= 1'b0;
    par <= 1'b0;
    host_model_inst.idle(1'b0);
    host_model_inst.wt(4);
    drove = 1'b0;
    host_model_inst.ser(1'b1, 8'hC3);
    rchk("rx serial", 4'h4, 32'h3C3);
    chk("ser drive", 32'h0, 32'(drove));
    rchk("straps ser", 4'h0, 32'h0000000C);
  endtask
  task automatic t_supply_init;
    @(posedge ref_clk);
    pwr_n <= 1'b0;
    div <= 1'b0;
    host_model_inst.wt(5);
    chk("supply", 32'h0, {30'h0, smode, sdiv});
    host_model_inst.ser(1'b0, 8'h3A);
    host_model_inst.ser(1'b0, 8'h5C);
    rchk("rx overrun", 4'h4, 32'h65C);
    @(posedge ref_clk);
    init_low_n <= 1'b0;
    host_model_inst.wt(5);
    init_low_n <= 1'b1;
    host_model_inst.wt(3);
    rchk("init rx", 4'h4, 32'h0);
    rchk("init rd", 4'h8, 32'h0);
  endtask
  task automatic conclude;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #1_000_000;
    num_errors++;
    conclude();
  end
  initial begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    style = 1'b0;
    drove = 1'b0;
    init_low_n = 1'b1;
    par = 1'b1;
    pwr_n = 1'b1;
    div = 1'b1;
    avs_address = 4'h0;
    avs_byteenable = 4'h1;
    avs_writedata = 32'h0;
    t_reset();
    t_regs();
    t_8080();
    t_6800();
    t_serial();
    t_supply_init();
    conclude();
  end
endmodule
